// ===== verilog/csc_smbus_slave.sv
/*
 * SMBus block read / block write slave exposing control byte 0 of a clock synthesizer.
 * Assumes SCL and SDA arrive as raw pins, far slower than the 200 MHz system clock.
 */
`timescale 1ns/1ps
module csc_smbus_slave (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_power_down_n,
    input wire logic i_cpu_clock_stop_n,
    input wire logic i_pci_clock_stop_n,
    input wire logic [2:0] i_freq_select,
    output csc_pkg::csc_ctrl_s o_ctrl,
    output logic o_pci_stop_eff_n
);

    // ****************************************************************
    // Pin synchronisation.
    // ****************************************************************
    logic scl_s;
    logic sda_s;
    csc_pkg::csc_pins_s pins_s;
    logic scl_d_ff;
    logic sda_d_ff;

    csc_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async({i_scl, i_sda}),
        .o_sync({scl_s, sda_s})
    );

    csc_sync #(.WIDTH(5), .RST_VAL(5'h18)) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async({i_cpu_clock_stop_n, i_pci_clock_stop_n, i_freq_select}),
        .o_sync(pins_s)
    );

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // ****************************************************************
    // Register file. Power-down does not gate any of this logic.
    // ****************************************************************
    csc_pkg::csc_ctrl_s ctrl_ff;
    logic pci_stop_reg_ff;
    logic [7:0] ctrl0_rd;

    assign o_pci_stop_eff_n = pci_stop_reg_ff & pins_s.pci_clock_stop_n;
    assign ctrl0_rd = {ctrl_ff.spread_en, ctrl_ff.pd_tristate, ctrl_ff.dual_48m,
                       pins_s.cpu_clock_stop_n,
                       o_pci_stop_eff_n,
                       pins_s.freq_select};
    assign o_ctrl = ctrl_ff;

    // ****************************************************************
    // Protocol state machine.
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WCOUNT,
        ST_WDATA,
        ST_RDATA,
        ST_SKIP
    } csc_state_e;

    csc_state_e state_ff;
    logic [7:0] shift_ff;
    logic [3:0] bit_cnt_ff;
    logic ack_phase_ff;
    logic tx_ff;
    logic [7:0] byte_idx_ff;
    logic cmd_ok_ff;
    logic drive_low_ff;
    logic host_nack_ff;

    // The slave only ever pulls low; a released line reads high through the pull-up.
    assign o_sda = 1'b0;
    assign o_sda_oe = drive_low_ff;

    function automatic logic [7:0] tx_byte(input logic [7:0] idx, input logic [7:0] ctrl0);
        if (idx == 8'h00) begin
            tx_byte = csc_pkg::BYTE_COUNT;
        end else if (idx == 8'h01) begin
            tx_byte = ctrl0;
        end else begin
            tx_byte = 8'hff;
        end
    endfunction

    logic [7:0] rx_byte;
    assign rx_byte = {shift_ff[6:0], sda_s};

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bit_cnt_ff <= 4'h0;
            ack_phase_ff <= 1'b0;
            tx_ff <= 1'b0;
            byte_idx_ff <= 8'h00;
            cmd_ok_ff <= 1'b0;
            drive_low_ff <= 1'b0;
            host_nack_ff <= 1'b0;
            ctrl_ff <= '{csc_pkg::RST_SPREAD_EN, csc_pkg::RST_PD_TRISTATE, csc_pkg::RST_DUAL_48M};
            pci_stop_reg_ff <= csc_pkg::RST_PCI_STOP_REG;
        end else if (stop_det) begin
            // Completed bytes already landed in the register; nothing rolls back.
            state_ff <= ST_IDLE;
            drive_low_ff <= 1'b0;
            // A read address is answered only in the transaction that sent the command.
            cmd_ok_ff <= 1'b0;
        end else if (start_det) begin
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            ack_phase_ff <= 1'b0;
            tx_ff <= 1'b0;
            drive_low_ff <= 1'b0;
        end else if (state_ff != ST_IDLE && state_ff != ST_SKIP) begin
            if (scl_rise && !ack_phase_ff) begin
                shift_ff <= rx_byte;
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_rise && ack_phase_ff && tx_ff) begin
                host_nack_ff <= sda_s;
            end
            if (scl_fall && !ack_phase_ff && bit_cnt_ff == csc_pkg::BITS_PER_BYTE) begin
                ack_phase_ff <= 1'b1;
                bit_cnt_ff <= 4'h0;
                drive_low_ff <= 1'b0;
                case (state_ff)
                    ST_ADDR: begin
                        if (shift_ff[7:1] == csc_pkg::SLAVE_ADDR && (shift_ff[0] == 1'b0 || cmd_ok_ff)) begin
                            drive_low_ff <= 1'b1;
                            tx_ff <= 1'b0;
                            byte_idx_ff <= 8'h00;
                        end else begin
                            state_ff <= ST_SKIP;
                            ack_phase_ff <= 1'b0;
                        end
                    end
                    ST_CMD: begin
                        drive_low_ff <= 1'b1;
                        cmd_ok_ff <= (shift_ff == csc_pkg::BLOCK_CMD);
                    end
                    ST_WCOUNT: begin
                        drive_low_ff <= 1'b1;
                    end
                    ST_WDATA: begin
                        drive_low_ff <= 1'b1;
                        if (byte_idx_ff == csc_pkg::REG_OFFSET_CTRL0) begin
                            // Read-only positions are dropped here.
                            ctrl_ff.spread_en <= shift_ff[csc_pkg::BIT_SPREAD_EN];
                            ctrl_ff.pd_tristate <= shift_ff[csc_pkg::BIT_PD_TRISTATE];
                            ctrl_ff.dual_48m <= shift_ff[csc_pkg::BIT_DUAL_48M];
                            pci_stop_reg_ff <= shift_ff[csc_pkg::BIT_PCI_STOP];
                        end
                        if (byte_idx_ff != 8'hff) begin
                            byte_idx_ff <= byte_idx_ff + 8'h01;
                        end
                    end
                    ST_RDATA: begin
                        drive_low_ff <= 1'b0;
                        byte_idx_ff <= byte_idx_ff + 8'h01;
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end else if (scl_fall && ack_phase_ff) begin
                ack_phase_ff <= 1'b0;
                if (state_ff == ST_ADDR && shift_ff[0]) begin
                    state_ff <= ST_RDATA;
                    tx_ff <= 1'b1;
                    shift_ff <= tx_byte(8'h00, ctrl0_rd);
                    drive_low_ff <= ~tx_byte(8'h00, ctrl0_rd) >> 7 == 8'h01;
                    bit_cnt_ff <= 4'h0;
                end else if (state_ff == ST_RDATA) begin
                    if (host_nack_ff) begin
                        state_ff <= ST_SKIP;
                        drive_low_ff <= 1'b0;
                    end else begin
                        shift_ff <= tx_byte(byte_idx_ff, ctrl0_rd);
                        drive_low_ff <= ~tx_byte(byte_idx_ff, ctrl0_rd) >> 7 == 8'h01;
                    end
                end else begin
                    drive_low_ff <= 1'b0;
                    case (state_ff)
                        ST_ADDR: state_ff <= ST_CMD;
                        ST_CMD: state_ff <= ST_WCOUNT;
                        ST_WCOUNT: state_ff <= ST_WDATA;
                        default: state_ff <= state_ff;
                    endcase
                end
            end else if (scl_fall && tx_ff && bit_cnt_ff != 4'h0) begin
                // Next bit goes out after SCL falls; rx path shifted the old MSB out already.
                drive_low_ff <= ~shift_ff[7];
            end
        end
    end

endmodule

// ===== verilog/csc_pkg.sv
/*
 * Shared constants and carrier types for the clock synthesizer's serial configuration port.
 * Assumes a single 200 MHz system clock; every other signal is sampled against it.
 */
package csc_pkg;

    // ****************************************************************
    // Addressing and protocol.
    // ****************************************************************
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam logic [7:0] BLOCK_CMD = 8'h00;
    localparam logic [7:0] REG_OFFSET_CTRL0 = 8'h00;
    localparam logic [7:0] BYTE_COUNT = 8'h01;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ****************************************************************
    // Control byte 0 layout and reset values.
    // ****************************************************************
    localparam int BIT_SPREAD_EN = 7;
    localparam int BIT_PD_TRISTATE = 6;
    localparam int BIT_DUAL_48M = 5;
    localparam int BIT_CPU_STOP = 4;
    localparam int BIT_PCI_STOP = 3;
    localparam logic RST_SPREAD_EN = 1'b0;
    localparam logic RST_PD_TRISTATE = 1'b0;
    localparam logic RST_DUAL_48M = 1'b0;
    localparam logic RST_PCI_STOP_REG = 1'b1;

    // ****************************************************************
    // Carrier types.
    // ****************************************************************
    typedef struct packed {
        logic spread_en;
        logic pd_tristate;
        logic dual_48m;
    } csc_ctrl_s;

    typedef struct packed {
        logic cpu_clock_stop_n;
        logic pci_clock_stop_n;
        logic [2:0] freq_select;
    } csc_pins_s;

endpackage

// ===== verilog/csc_sync.sv
/*
 * Two-stage synchroniser bank for asynchronous pin inputs.
 * Assumes inputs may change at any time relative to i_sys_clk.
 */
`timescale 1ns/1ps
module csc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // The first stage feeds only the second; metastability settles there.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule

// ===== tb/csc_smbus_slave_props.sv
/* Checker on the pins of csc_smbus_slave, bound in by the bench.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module csc_smbus_slave_props (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic i_pci_clock_stop_n,
    input wire csc_pkg::csc_ctrl_s o_ctrl,
    input wire logic o_pci_stop_eff_n
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sda_value_a: assert property (o_sda == 1'b0)
        else $error("data line value not low");
    reset_values_a: assert property ($fell(i_rst) |-> o_ctrl == 3'h0 && !o_sda_oe)
        else $error("outputs not at defaults after reset");
    oe_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("data drive began while clock high");
    oe_fall_a: assert property ($fell(o_sda_oe) |-> !i_scl)
        else $error("data drive ended while clock high");
    oe_hold_a: assert property (i_scl [*4] |-> $stable(o_sda_oe))
        else $error("data drive changed in clock high");
    stop_release_a: assert property (i_scl && $rose(i_sda) |=> !o_sda_oe [*8])
        else $error("data driven after stop");
    // The pin passes two synchroniser stages, so the pin of two edges back decides.
    pci_low_a: assert property (
        !$past(i_rst) && !$past(i_rst, 2) && !$past(i_pci_clock_stop_n, 2) && !$past(i_pci_clock_stop_n, 3)
        |-> !o_pci_stop_eff_n) else $error("pci stop high while pin low");
    pci_high_a: assert property (
        !$past(i_rst) && !$past(i_rst, 2) && o_pci_stop_eff_n |-> $past(i_pci_clock_stop_n, 2))
        else $error("pci stop high without pin high");
endmodule

// ===== tb/csc_host_model.sv
/* Behavioural SMBus host controller driving the serial clock and data lines.
   Assumes a pull-up on the data line, resolved by the bench into i_sda. */
`timescale 1ns/1ps
module csc_host_model (
    input wire logic i_sys_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // A third of the 120 ns serial clock period, in system cycles.
    localparam int QTR = 8;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Lines change just after an edge and hold a third of a period, so the port never sees a race.
    task automatic step(input logic scl, input logic low);
        @(posedge i_sys_clk);
        o_scl <= scl;
        o_sda_low <= low;
        repeat (QTR - 1) @(posedge i_sys_clk);
    endtask
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    // Nine bits go out and the line level is caught in the middle of each high phase.
    task automatic xfer(input logic [8:0] v, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, !v[i]);
            step(1'b1, !v[i]);
            r[i] = i_sda;
            step(1'b1, !v[i]);
        end
    endtask
endmodule

// ===== tb/csc_smbus_slave_tb.sv
/* Self-checking bench: host model on the serial lines, expectations queued.
   Assumes the package, the design and the host model are compiled first. */
`timescale 1ns/1ps
module csc_smbus_slave_tb;
    logic clk, rst, pd_n, cpu_n, pci_n, oe, sda_v, scl, h_low, eff_n, pci_reg;
    logic [2:0] sel, ctrl_m;
    csc_pkg::csc_ctrl_s ctrl;
    wire sda;
    integer seed;
    int bad_count, n_checks;
    logic [8:0] exp_q[$], got_q[$];
    string nm_q[$];
    // Pull-up on the data line: it reads high once nobody drives it.
    assign sda = !(h_low || (oe && !sda_v));
    csc_smbus_slave dut (.i_sys_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_v),
        .o_sda_oe(oe), .i_power_down_n(pd_n), .i_cpu_clock_stop_n(cpu_n), .i_pci_clock_stop_n(pci_n),
        .i_freq_select(sel), .o_ctrl(ctrl), .o_pci_stop_eff_n(eff_n));
    csc_host_model host (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(h_low));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict();
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check_val(input string nm, input logic [8:0] s, input logic [8:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmp(input string nm, input logic [8:0] g, input logic [8:0] e);
        nm_q.push_back(nm);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask
    task automatic tx(input string nm, input logic [8:0] v, input logic [8:0] e);
        logic [8:0] r;
        host.xfer(v, r);
        cmp(nm, r, e);
    endtask
    function automatic logic [8:0] byte0();
        return {ctrl_m, cpu_n, pci_reg & pci_n, sel, 1'b1};
    endfunction
    task automatic head(input logic rd);
        host.start();
        tx("addr", 9'h1a5, 9'h1a4);
        tx("cmd", 9'h001, 9'h000);
        if (rd) begin
            host.start();
            tx("raddr", 9'h1a7, 9'h1a6);
            tx("count", 9'h1fe, 9'h002);
            tx("byte0", 9'h1ff, byte0());
            host.stop();
        end
    endtask
    task automatic wr(input logic [7:0] d, input int n);
        head(1'b0);
        if (n > 0) begin
            tx("wcount", {n[7:0], 1'b1}, {n[7:0], 1'b0});
            tx("wdata", {d, 1'b1}, {d, 1'b0});
            ctrl_m = d[7:5];
            pci_reg = d[3];
        end
        if (n > 1) begin
            tx("wextra", {~d, 1'b1}, {~d, 1'b0});
        end
        host.stop();
    endtask
    always @(posedge clk) begin
        while (got_q.size() > 0) begin
            check_val(nm_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        seed = 17234;
        rst = 1'b1;
        {pd_n, cpu_n, pci_n, sel} = 6'h3f;
        ctrl_m = 3'h0;
        pci_reg = 1'b1;
        bad_count = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        head(1'b1);
        for (int k = 0; k < 9; k++) begin
            {pd_n, cpu_n, pci_n, sel} <= 6'($random(seed));
            wr(8'($random(seed)), k % 3);
            cmp("ctrl", {6'h0, ctrl}, {6'h0, ctrl_m});
            cmp("eff", {8'h0, eff_n}, {8'h0, pci_reg & pci_n});
            head(1'b1);
        end
        host.start();
        tx("badaddr", 9'h1a9, 9'h1a9);
        host.stop();
        host.start();
        tx("nocmd", 9'h1a7, 9'h1a7);
        host.stop();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ctrl_m = 3'h0;
        pci_reg = 1'b1;
        repeat (3) @(posedge clk);
        cmp("rstctrl", {6'h0, ctrl}, 9'h000);
        head(1'b1);
        for (int w = 0; w < 50 && got_q.size() > 0; w++) begin
            @(posedge clk);
        end
        if (got_q.size() > 0) begin
            bad_count++;
        end
        give_verdict();
    end
endmodule
bind csc_smbus_slave csc_smbus_slave_props u_props (.i_sys_clk, .i_rst, .i_scl, .i_sda, .o_sda,
    .o_sda_oe, .i_pci_clock_stop_n, .o_ctrl, .o_pci_stop_eff_n);
